// ==== hw/sram_ctrl_defs.svh ====
`ifndef SRAM_CTRL_DEFS_SVH
`define SRAM_CTRL_DEFS_SVH

// bus widths of the memory
`define DATA_W        24
`define ADDR_W        19
`define LANES         3
`define LANE_W        8

// timing figures in ns, cycle counts derived at 20 ns per cycle
`define CLK_PERIOD_NS 20
`define T_RC_NS       10
`define T_PWE_NS      7
`define T_HZWE_NS     5
`define T_SD_NS       6
`define T_CDR_NS      0
`define CEIL_CYC(ns) \
  ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define RD_CYC        `CEIL_CYC(`T_RC_NS)
`define WR_CYC        `CEIL_CYC(`T_PWE_NS)
`define TURN_CYC      `CEIL_CYC(`T_HZWE_NS + `T_SD_NS)
`define RET_CYC       `CEIL_CYC(`T_CDR_NS)
`define CNT_W         4
`define LANES_OFF     3'h7
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1

`endif

// ==== hw/sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;
  // controller sequence states
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_DATA,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RETAIN
  } state_t;
endpackage : sram_ctrl_pkg

// ==== hw/lane_pins.sv ====
`include "sram_ctrl_defs.svh"

// per-lane data pin direction and capture; one lane per loop iteration
module lane_pins
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [`LANES-1:0]    sel_n_in,
  input  wire logic                 drive_in,
  input  wire logic                 capture_in,
  input  wire logic [`DATA_W-1:0]   wdata_in,
  input  wire logic [`DATA_W-1:0]   pins_in,
  output logic      [`DATA_W-1:0]   pins_out,
  output logic      [`DATA_W-1:0]   pins_oe_out,
  output logic      [`DATA_W-1:0]   rdata_out
);
  // drive only lanes that are selected for a write; pins_out and pins_oe_out share
  // one process and rdata_out has its own, so each vector has a single writer
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pins_out    <= '0;
      pins_oe_out <= '0;
    end
    else
    begin
      pins_out <= wdata_in;
      for (int ln = 0; ln < `LANES; ln++)
        pins_oe_out[ln*`LANE_W +: `LANE_W] <=
          {`LANE_W{drive_in & ~sel_n_in[ln]}};
    end
  end

  // unselected lanes read back as zero
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= '0;
    else if (capture_in)
      for (int ln = 0; ln < `LANES; ln++)
        rdata_out[ln*`LANE_W +: `LANE_W] <= sel_n_in[ln] ? '0 :
          pins_in[ln*`LANE_W +: `LANE_W];
  end
endmodule : lane_pins

// ==== hw/sram_host_ctrl.sv ====
// Summary of operation
// - controller holds strobe high during reads
// - controller stops driving after strobe write
// - address latched on the same edge that select falls
// - all selects high before retention
// - write is select and strobe overlap
`include "sram_ctrl_defs.svh"

module sram_host_ctrl
(
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 RST_N_IN,
  input  wire logic                 REQ_IN,
  input  wire logic                 REQ_WRITE_IN,
  input  wire logic [`LANES-1:0]    REQ_LANES_IN,
  input  wire logic [`ADDR_W-1:0]   REQ_ADDR_IN,
  input  wire logic [`DATA_W-1:0]   REQ_WDATA_IN,
  input  wire logic                 RETAIN_REQ_IN,
  input  wire logic [`DATA_W-1:0]   DATA_PINS_IN,
  output logic                      BUSY_OUT,
  output logic                      DONE_OUT,
  output logic      [`DATA_W-1:0]   RDATA_OUT,
  output logic                      RETAIN_READY_OUT,
  output logic      [`ADDR_W-1:0]   ADDR_OUT,
  output logic                      LANE0_SELECT_N_OUT,
  output logic                      LANE1_SELECT_N_OUT,
  output logic                      LANE2_SELECT_N_OUT,
  output logic                      WRITE_STROBE_N_OUT,
  output logic                      OUTPUT_GATE_N_OUT,
  output logic      [`DATA_W-1:0]   DATA_PINS_OUT,
  output logic      [`DATA_W-1:0]   DATA_PINS_OE_OUT
);
  sram_ctrl_pkg::state_t      state_q;
  logic [`CNT_W-1:0]          cnt_q;
  logic [`LANES-1:0]          sel_n_q;
  logic                       we_n_q;
  logic                       oe_n_q;
  logic                       write_q;
  logic [`DATA_W-1:0]         wdata_q;
  logic                       drive_d;
  logic                       capture_d;

  // zero when the wait for this state has run out
  function automatic logic cnt_done(input logic [`CNT_W-1:0] c);
    cnt_done = (c == `CNT_ZERO);
  endfunction : cnt_done

  // drive from the strobe's fall until a cycle after it rises, so the data
  // sets up inside the overlap and holds across the terminating edge
  assign drive_d   = (state_q == sram_ctrl_pkg::ST_WR_SETUP) ||
                     (state_q == sram_ctrl_pkg::ST_WR_PULSE);
  assign capture_d = (state_q == sram_ctrl_pkg::ST_RD_DATA) && cnt_done(cnt_q);

  // sequencer: address and select on one edge, then gate or strobe
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= sram_ctrl_pkg::ST_IDLE;
      cnt_q   <= `CNT_ZERO;
      write_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        sram_ctrl_pkg::ST_IDLE:
        begin
          if (RETAIN_REQ_IN)
          begin
            state_q <= sram_ctrl_pkg::ST_RETAIN;
            cnt_q   <= `CNT_ONE;
          end
          else if (REQ_IN && (REQ_LANES_IN != '0))
          begin
            write_q <= REQ_WRITE_IN;
            state_q <= REQ_WRITE_IN ? sram_ctrl_pkg::ST_WR_SETUP
                                    : sram_ctrl_pkg::ST_RD_ADDR;
          end
        end
        sram_ctrl_pkg::ST_RD_ADDR:
        begin
          state_q <= sram_ctrl_pkg::ST_RD_DATA;
          cnt_q   <= `CNT_W'(`RD_CYC - 1);
        end
        sram_ctrl_pkg::ST_RD_DATA:
        begin
          if (cnt_done(cnt_q))
            state_q <= sram_ctrl_pkg::ST_IDLE;
          else
            cnt_q <= cnt_q - `CNT_ONE;
        end
        sram_ctrl_pkg::ST_WR_SETUP:
        begin
          state_q <= sram_ctrl_pkg::ST_WR_PULSE;
          cnt_q   <= `CNT_W'(`WR_CYC - 1);
        end
        sram_ctrl_pkg::ST_WR_PULSE:
        begin
          if (cnt_done(cnt_q))
          begin
            state_q <= sram_ctrl_pkg::ST_WR_END;
            cnt_q   <= `CNT_W'(`TURN_CYC - 1);
          end
          else
            cnt_q <= cnt_q - `CNT_ONE;
        end
        sram_ctrl_pkg::ST_WR_END:
        begin
          if (cnt_done(cnt_q))
            state_q <= sram_ctrl_pkg::ST_IDLE;
          else
            cnt_q <= cnt_q - `CNT_ONE;
        end
        sram_ctrl_pkg::ST_RETAIN:
        begin
          if (!RETAIN_REQ_IN)
            state_q <= sram_ctrl_pkg::ST_IDLE;
          else if (!cnt_done(cnt_q))
            cnt_q <= cnt_q - `CNT_ONE;
        end
      endcase
    end
  end

  // address and write data latched at acceptance, held through the access
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ADDR_OUT <= '0;
      wdata_q  <= '0;
    end
    else if (state_q == sram_ctrl_pkg::ST_IDLE && REQ_IN && !RETAIN_REQ_IN)
    begin
      ADDR_OUT <= REQ_ADDR_IN;
      wdata_q  <= REQ_WDATA_IN;
    end
  end

  // lane selects: low only inside an access, all high otherwise
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      sel_n_q <= `LANES_OFF;
    else if (state_q == sram_ctrl_pkg::ST_IDLE && REQ_IN && !RETAIN_REQ_IN)
      sel_n_q <= ~REQ_LANES_IN;
    else if ((state_q == sram_ctrl_pkg::ST_RD_DATA && cnt_done(cnt_q)) ||
             (state_q == sram_ctrl_pkg::ST_WR_END && cnt_done(cnt_q)) ||
             state_q == sram_ctrl_pkg::ST_RETAIN)
      sel_n_q <= `LANES_OFF;
  end

  // strobe: low for the pulse only; reads keep it high throughout
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      we_n_q <= 1'b1;
    else if (state_q == sram_ctrl_pkg::ST_WR_SETUP)
      we_n_q <= 1'b0;
    else
      we_n_q <= 1'b1;
  end
  // strobe rises while selects stay low, so the strobe ends the write

  // gate: low only in a read; high for writes so pins never turn around
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      oe_n_q <= 1'b1;
    else if (state_q == sram_ctrl_pkg::ST_RD_ADDR)
      oe_n_q <= 1'b0;
    else if (state_q == sram_ctrl_pkg::ST_RD_DATA && cnt_done(cnt_q))
      oe_n_q <= 1'b1;
    else if (write_q)
      oe_n_q <= 1'b1;
  end

  // status toward the requester
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      BUSY_OUT         <= 1'b0;
      DONE_OUT         <= 1'b0;
      RETAIN_READY_OUT <= 1'b0;
    end
    else
    begin
      BUSY_OUT <= (state_q != sram_ctrl_pkg::ST_IDLE) ||
                  REQ_IN || RETAIN_REQ_IN;
      DONE_OUT <= capture_d ||
                  (state_q == sram_ctrl_pkg::ST_WR_END && cnt_done(cnt_q));
      RETAIN_READY_OUT <= (state_q == sram_ctrl_pkg::ST_RETAIN) &&
                          cnt_done(cnt_q) && RETAIN_REQ_IN;
    end
  end

  assign LANE0_SELECT_N_OUT = sel_n_q[0];
  assign LANE1_SELECT_N_OUT = sel_n_q[1];
  assign LANE2_SELECT_N_OUT = sel_n_q[2];
  assign WRITE_STROBE_N_OUT = we_n_q;
  assign OUTPUT_GATE_N_OUT  = oe_n_q;

  // data pin drivers and read capture, lane by lane
  lane_pins u_lane_pins
  (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (RST_N_IN),
    .sel_n_in    (sel_n_q),
    .drive_in    (drive_d),
    .capture_in  (capture_d),
    .wdata_in    (wdata_q),
    .pins_in     (DATA_PINS_IN),
    .pins_out    (DATA_PINS_OUT),
    .pins_oe_out (DATA_PINS_OE_OUT),
    .rdata_out   (RDATA_OUT)
  );
endmodule : sram_host_ctrl

// ==== bench/sram_model.sv ====
// behavioural memory on the far side, with the host's drive merged in
module sram_model
(
  input  wire logic        clk_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [2:0]  sel_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [23:0] ctl_d_in,
  input  wire logic [23:0] ctl_oe_in,
  output logic      [23:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] mem [0:15];
  logic        t_q = 1'h0;

  // float pattern flips each cycle so a stale capture never matches
  always_ff @(posedge clk_in)
    t_q <= ~t_q;

  // only bits the host really drives are stored, so the race at write end
  // between strobe rising and drive release cannot store a float
  always @*
  begin
    for (int i = 0; i < 24; i++)
      if (!we_n_in && !sel_n_in[i/8] && ctl_oe_in[i])
        mem[addr_in[3:0]][i] = ctl_d_in[i];
  end

  // a lane drives only when selected, strobe high and gate low
  always_comb
  begin
    for (int i = 0; i < 24; i++)
      if (ctl_oe_in[i])
        pins_out[i] = ctl_d_in[i];
      else if (!sel_n_in[i/8] && we_n_in && !oe_n_in)
        pins_out[i] = mem[addr_in[3:0]][i];
      else
        pins_out[i] = t_q ^ i[0];
  end
endmodule : sram_model

// ==== bench/sram_host_ctrl_monitor.sv ====
`include "sram_ctrl_defs.svh"

module sram_host_ctrl_monitor
(
  input wire logic                SYS_CLK_IN,
  input wire logic                RST_N_IN,
  input wire logic                REQ_IN,
  input wire logic                REQ_WRITE_IN,
  input wire logic [`LANES-1:0]   REQ_LANES_IN,
  input wire logic                RETAIN_REQ_IN,
  input wire logic                BUSY_OUT,
  input wire logic                DONE_OUT,
  input wire logic                RETAIN_READY_OUT,
  input wire logic [`ADDR_W-1:0]  ADDR_OUT,
  input wire logic                LANE0_SELECT_N_OUT,
  input wire logic                LANE1_SELECT_N_OUT,
  input wire logic                LANE2_SELECT_N_OUT,
  input wire logic                WRITE_STROBE_N_OUT,
  input wire logic                OUTPUT_GATE_N_OUT,
  input wire logic [`DATA_W-1:0]  DATA_PINS_OE_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  logic off;
  logic take;

  // device deselected, and an access accepted in idle
  assign off = LANE0_SELECT_N_OUT & LANE1_SELECT_N_OUT & LANE2_SELECT_N_OUT;
  assign take = !BUSY_OUT && REQ_IN && !RETAIN_REQ_IN && |REQ_LANES_IN;

  a_read_strobe: assert property (!OUTPUT_GATE_N_OUT |-> WRITE_STROBE_N_OUT
    && !off && !(|DATA_PINS_OE_OUT)) else $error("gate low in bad state");
  a_write_gate: assert property (!WRITE_STROBE_N_OUT |-> OUTPUT_GATE_N_OUT
    && !off) else $error("strobe low without select or with gate");
  a_drive_gate: assert property (|DATA_PINS_OE_OUT |-> OUTPUT_GATE_N_OUT)
    else $error("host drives while gate low");
  a_addr_hold: assert property (!off && $past(!off) |-> $stable(ADDR_OUT))
    else $error("address moved while selected");
  a_retain_off: assert property (RETAIN_READY_OUT |-> off
    && !(|DATA_PINS_OE_OUT)) else $error("ready while selected");
  a_retain_entry: assert property (!BUSY_OUT && RETAIN_REQ_IN |=> off
    ##2 (RETAIN_READY_OUT || !RETAIN_REQ_IN)) else $error("retain slow");
  a_read_done: assert property (take && !REQ_WRITE_IN |->
    !DONE_OUT [*3] ##1 DONE_OUT) else $error("read done timing");
  a_write_done: assert property (take && REQ_WRITE_IN |->
    !DONE_OUT [*4] ##1 DONE_OUT) else $error("write done timing");
  a_done_pulse: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");
endmodule : sram_host_ctrl_monitor

bind sram_host_ctrl sram_host_ctrl_monitor mon (.SYS_CLK_IN, .RST_N_IN,
  .REQ_IN, .REQ_WRITE_IN, .REQ_LANES_IN, .RETAIN_REQ_IN, .BUSY_OUT,
  .DONE_OUT, .RETAIN_READY_OUT, .ADDR_OUT, .LANE0_SELECT_N_OUT,
  .LANE1_SELECT_N_OUT, .LANE2_SELECT_N_OUT, .WRITE_STROBE_N_OUT,
  .OUTPUT_GATE_N_OUT, .DATA_PINS_OE_OUT);

// ==== bench/byte_lane_async_sram_access_test.sv ====
module byte_lane_async_sram_access_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, req, req_w, ret, busy, done, rdy;
  logic        s0, s1, s2, we_n, oe_n;
  logic [2:0]  lanes;
  logic [18:0] addr, a;
  logic [23:0] wdata, pins, rdata, dq, dq_oe;
  int          errors, n_tests;

  sram_host_ctrl uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req),
    .REQ_WRITE_IN(req_w), .REQ_LANES_IN(lanes), .REQ_ADDR_IN(addr),
    .REQ_WDATA_IN(wdata), .RETAIN_REQ_IN(ret), .DATA_PINS_IN(pins),
    .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata),
    .RETAIN_READY_OUT(rdy), .ADDR_OUT(a), .LANE0_SELECT_N_OUT(s0),
    .LANE1_SELECT_N_OUT(s1), .LANE2_SELECT_N_OUT(s2),
    .WRITE_STROBE_N_OUT(we_n), .OUTPUT_GATE_N_OUT(oe_n),
    .DATA_PINS_OUT(dq), .DATA_PINS_OE_OUT(dq_oe));
  sram_model mem (.clk_in(clk), .addr_in(a), .sel_n_in({s2, s1, s0}),
    .we_n_in(we_n), .oe_n_in(oe_n), .ctl_d_in(dq), .ctl_oe_in(dq_oe),
    .pins_out(pins));

  // 50 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [23:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // one access: request for one cycle, then wait for done, bounded
  task automatic acc(input logic w, input logic [2:0] ln,
                     input logic [18:0] ad, input logic [23:0] d);
    int k;
    @(negedge clk);
    req = 1'h1;
    req_w = w;
    lanes = ln;
    addr = ad;
    wdata = d;
    @(negedge clk);
    req = 1'h0;
    for (k = 0; k < 8 && done !== 1'h1; k++)
      @(negedge clk);
    if (k == 8)
    begin
      errors++;
      test_done();
    end
  endtask : acc

  task automatic t_reset();
    chk("idle pins", 24'h1F, {19'h0, s2, s1, s0, we_n, oe_n});
    chk("idle oe", 24'h0, dq_oe);
  endtask : t_reset

  // back-to-back full words, near-top address 7FFFA
  task automatic t_full();
    acc(1'h1, 3'h7, 19'h7FFFA, 24'h123456);
    chk("addr", 24'h07FFFA, {5'h0, a});
    acc(1'h1, 3'h7, 19'h5, 24'hFEDCBA);
    acc(1'h0, 3'h7, 19'h7FFFA, 24'h0);
    chk("full a", 24'h123456, rdata);
    acc(1'h0, 3'h7, 19'h5, 24'h0);
    chk("full b", 24'hFEDCBA, rdata);
  endtask : t_full

  // each lane written alone over a cleared word
  task automatic t_lanes();
    logic [23:0] e;
    for (int i = 0; i < 3; i++)
    begin
      e = 24'hABCDEF & (24'hFF << (8 * i));
      acc(1'h1, 3'h7, 19'h3, 24'h0);
      acc(1'h1, 3'h1 << i, 19'h3, 24'hABCDEF);
      acc(1'h0, 3'h7, 19'h3, 24'h0);
      chk("lane write", e, rdata);
      acc(1'h0, 3'h1 << i, 19'h3, 24'h0);
      chk("lane read", e, rdata);
    end
  endtask : t_lanes

  // two lanes read, empty lane mask refused
  task automatic t_pair();
    acc(1'h0, 3'h5, 19'h7FFFA, 24'h0);
    chk("two lanes", 24'h120056, rdata);
    @(negedge clk);
    req = 1'h1;
    lanes = 3'h0;
    repeat (3) @(negedge clk);
    chk("empty busy", 24'h1, {23'h0, busy});
    chk("empty mask", 24'h7, {21'h0, s2, s1, s0});
    req = 1'h0;
  endtask : t_pair

  task automatic t_retain();
    int k;
    @(negedge clk);
    ret = 1'h1;
    for (k = 0; k < 8 && rdy !== 1'h1; k++)
      @(negedge clk);
    chk("ready", 24'h1, {23'h0, rdy});
    chk("retain sel", 24'h7, {21'h0, s2, s1, s0});
    chk("retain oe", 24'h0, dq_oe);
    ret = 1'h0;
    repeat (3) @(negedge clk);
    acc(1'h0, 3'h7, 19'h5, 24'h0);
    chk("after retain", 24'hFEDCBA, rdata);
  endtask : t_retain

  initial
  begin
    {rst_n, req, req_w, ret, lanes, addr, wdata} = '0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    t_reset();
    t_full();
    t_lanes();
    t_pair();
    t_retain();
    test_done();
  end
endmodule : byte_lane_async_sram_access_test
